// ### hw/lsync_pkg.sv
// constants shared by the sync control block, its checker and its test bench
// assumes a 25 MHz bus clock and a 32-bit axi4-lite register bus
package lsync_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int unsigned CLK_HZ       = 25_000_000;
	localparam int unsigned TIMER_HZ     = 5_000_000;
	localparam int unsigned TICK_DIV     = CLK_HZ / TIMER_HZ;
	localparam int unsigned DIV_W        = $clog2(TICK_DIV);
	localparam int unsigned SELF_CLR_US  = 15;
	localparam int unsigned SELF_CLR_CYC = (SELF_CLR_US * (CLK_HZ / 1_000_000) + 0) < 1 ? 1 :
		SELF_CLR_US * (CLK_HZ / 1_000_000);
	localparam int unsigned CLR_W        = $clog2(SELF_CLR_CYC + 1);

	// ****************************************
	// register offsets
	// ****************************************
	localparam int unsigned ADDR_W        = 8;
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_EDGE_CFG  = 8'h04;
	localparam logic [7:0]  OFS_TIMER     = 8'h08;
	localparam logic [7:0]  OFS_CMP       = 8'h0c;
	localparam logic [7:0]  OFS_STATUS    = 8'h10;

	// ****************************************
	// control bit positions
	// ****************************************
	localparam int unsigned CTL_UNIT_RST  = 0;
	localparam int unsigned CTL_EDGE_CLR  = 1;
	localparam int unsigned CTL_SYNC_EN   = 2;
	localparam int unsigned CTL_START_IE  = 3;
	localparam int unsigned CTL_STOP_IE   = 4;
	localparam int unsigned CTL_CMP_IE    = 5;
	localparam int unsigned CTL_MODE      = 6;
	localparam int unsigned CTL_EDGE_TYPE = 7;

	// ****************************************
	// fields, status bits, reset values
	// ****************************************
	localparam int unsigned CFG_START_LSB = 0;
	localparam int unsigned CFG_STOP_LSB  = 4;
	localparam int unsigned STA_START     = 1;
	localparam int unsigned STA_STOP      = 2;
	localparam int unsigned STA_CMP       = 3;
	localparam int unsigned TIMER_W       = 16;
	localparam logic [7:0]  CTRL_RESET    = 8'h00;
	localparam logic [7:0]  CFG_RESET     = 8'h32;
	localparam logic [15:0] CMP_RESET     = 16'h0000;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage : lsync_pkg

// ### hw/lsync_pin_sync.sv
// three-stage synchroniser with agreement filter for the bus pin
// assumes the pin idles high, as a recessive single-wire bus does
`timescale 1ns/1ps
module lsync_pin_sync (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// pin side
	input  wire logic pin_in,
	// filtered level and edges
	output logic      level,
	output logic      rise,
	output logic      fall
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
		logic rise;
		logic fall;
	} lsync_pin_s;

	localparam lsync_pin_s RST_S = '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1, default: 1'b0};

	lsync_pin_s q;
	lsync_pin_s d;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		d      = q;
		d.s1   = pin_in;
		d.s2   = q.s1;
		d.s3   = q.s2;
		d.rise = 1'b0;
		d.fall = 1'b0;
		// a change counts once stages two and three agree
		if ((q.s2 == q.s3) && (q.s2 != q.level)) begin
			d.level = q.s2;
			d.rise  = q.s2;
			d.fall  = ~q.s2;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= RST_S;
		end else begin
			q <= d;
		end
	end

	assign level = q.level;
	assign rise  = q.rise;
	assign fall  = q.fall;

endmodule : lsync_pin_sync

// ### hw/lsync_core.sv
// sync timer control block with axi4-lite register slave
// assumes one 25 MHz clock and the bus receive pin on lin_rx
// What this block does
// R01: edge-type bit picks falling or rising stop count
// R02: mode bit selects LIN or pulse-width mode
// R03: compare enable gates timer-equals-compare interrupt
// R04: compare event sets status bit three
// R05: software times pulse widths with compare events
// R06: stop enable gates stop-condition interrupt
// R07: start enable gates start-condition interrupt
// R08: sync enable bit turns edge counting and the sync timer on
// R09: edge-clear bit clears counters, self-clears after 15us
// R10: reset bit defaults unit, self-clears after 15us
// R11: sync timer counts at 5 MHz
// R12: timer starts on configured falling edge, default second
// R13: timer stops on configured edge count, default third
// R14: timer holds final count until cleared or restarted by the next start event
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module lsync_core (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// write address channel
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// write data channel
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// write response channel
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// read address channel
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// read data channel
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// bus pin and interrupt
	input  wire logic        lin_rx,
	output logic             sync_irq
);

	typedef struct packed {
		logic                              aw_full;
		logic [7:0]                        aw_addr;
		logic                              w_full;
		logic [31:0]                       w_data;
		logic [3:0]                        w_strb;
		logic                              awready;
		logic                              wready;
		logic                              bvalid;
		logic [1:0]                        bresp;
		logic                              arready;
		logic                              rvalid;
		logic [31:0]                       rdata;
		logic [1:0]                        rresp;
		logic [7:0]                        ctrl;
		logic [7:0]                        cfg;
		logic [15:0]                       cmp;
		logic [lsync_pkg::TIMER_W-1:0]     timer;
		logic [3:0]                        sta;
		logic [lsync_pkg::CLR_W-1:0]       clr_cnt;
		logic [lsync_pkg::CLR_W-1:0]       rst_cnt;
		logic [lsync_pkg::DIV_W-1:0]       div;
		logic                              running;
		logic [3:0]                        fall_cnt;
		logic [3:0]                        rise_cnt;
		logic                              irq;
	} lsync_state_s;

	localparam lsync_state_s RST_S = '{ctrl: lsync_pkg::CTRL_RESET,
		cfg: lsync_pkg::CFG_RESET, cmp: lsync_pkg::CMP_RESET, default: '0};
	localparam logic [lsync_pkg::CLR_W-1:0] CLR_LOAD = lsync_pkg::CLR_W'(lsync_pkg::SELF_CLR_CYC);
	localparam logic [lsync_pkg::DIV_W-1:0] DIV_LAST = lsync_pkg::DIV_W'(lsync_pkg::TICK_DIV - 1);

	lsync_state_s q;
	lsync_state_s d;
	logic         pin_rise;
	logic         pin_fall;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == lsync_pkg::OFS_CTRL) || (a == lsync_pkg::OFS_EDGE_CFG) ||
			(a == lsync_pkg::OFS_TIMER) || (a == lsync_pkg::OFS_CMP) ||
			(a == lsync_pkg::OFS_STATUS);
	endfunction : is_mapped

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			wmerge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction : wmerge

	function automatic logic [3:0] sat_inc(input logic [3:0] v);
		sat_inc = (v == 4'hf) ? v : v + 4'h1;
	endfunction : sat_inc

	// ****************************************
	// pin front end
	// ****************************************
	lsync_pin_sync i_lsync_pin_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin_in  (lin_rx),
		.level   (),
		.rise    (pin_rise),
		.fall    (pin_fall)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic        aw_take;
		logic        w_take;
		logic [7:0]  wa;
		logic [31:0] wd;
		logic [3:0]  ws;
		logic [31:0] nv;
		logic        tick;
		logic        en;
		logic        start_ev;
		logic        stop_ev;
		logic        cmp_ev;
		logic [3:0]  nf;
		logic [3:0]  nr;
		logic [15:0] nt;
		aw_take  = s_axi_awvalid & q.awready;
		w_take   = s_axi_wvalid & q.wready;
		wa       = q.aw_full ? q.aw_addr : s_axi_awaddr;
		wd       = q.w_full ? q.w_data : s_axi_wdata;
		ws       = q.w_full ? q.w_strb : s_axi_wstrb;
		nv       = 32'h0;
		start_ev = 1'b0;
		stop_ev  = 1'b0;
		cmp_ev   = 1'b0;
		nf       = sat_inc(q.fall_cnt);
		nr       = sat_inc(q.rise_cnt);
		nt       = q.timer + 16'h1;
		tick     = (q.div == DIV_LAST); // R11
		en       = q.ctrl[lsync_pkg::CTL_SYNC_EN] & ~q.ctrl[lsync_pkg::CTL_UNIT_RST]; // R08
		d        = q;

		// self-clearing control bits
		if (q.clr_cnt != '0) begin
			d.clr_cnt = q.clr_cnt - 1'b1;
			if (q.clr_cnt == 1) d.ctrl[lsync_pkg::CTL_EDGE_CLR] = 1'b0; // R09
		end
		if (q.rst_cnt != '0) begin
			d.rst_cnt = q.rst_cnt - 1'b1;
			if (q.rst_cnt == 1) d.ctrl[lsync_pkg::CTL_UNIT_RST] = 1'b0; // R10
		end

		// write channels
		if (aw_take) begin
			d.aw_full = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (w_take) begin
			d.w_full = 1'b1;
			d.w_data = s_axi_wdata;
			d.w_strb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
		if ((q.aw_full | aw_take) && (q.w_full | w_take) && !q.bvalid) begin
			d.aw_full = 1'b0;
			d.w_full  = 1'b0;
			d.bvalid  = 1'b1;
			d.bresp   = is_mapped(wa) ? lsync_pkg::RESP_OKAY : lsync_pkg::RESP_SLVERR;
			case (wa)
				lsync_pkg::OFS_CTRL: begin
					nv     = wmerge({24'h0, q.ctrl}, wd, ws);
					d.ctrl = nv[7:0] | (d.ctrl & 8'h03);
					if (ws[0] && wd[lsync_pkg::CTL_EDGE_CLR]) d.clr_cnt = CLR_LOAD; // R09
					if (ws[0] && wd[lsync_pkg::CTL_UNIT_RST]) d.rst_cnt = CLR_LOAD; // R10
				end
				lsync_pkg::OFS_EDGE_CFG: begin
					nv    = wmerge({24'h0, q.cfg}, wd, ws);
					d.cfg = nv[7:0];
				end
				lsync_pkg::OFS_CMP: begin
					nv    = wmerge({16'h0, q.cmp}, wd, ws);
					d.cmp = nv[15:0];
				end
				lsync_pkg::OFS_STATUS: begin
					nv    = wmerge(32'h0, wd, ws);
					d.sta = q.sta & ~nv[3:0];
				end
				default: nv = 32'h0;
			endcase
		end
		// read channels
		if (q.rvalid && s_axi_rready) d.rvalid = 1'b0;
		if (s_axi_arvalid && q.arready) begin
			d.rvalid = 1'b1;
			d.rresp  = is_mapped(s_axi_araddr) ? lsync_pkg::RESP_OKAY : lsync_pkg::RESP_SLVERR;
			case (s_axi_araddr)
				lsync_pkg::OFS_CTRL:     d.rdata = {24'h0, q.ctrl};
				lsync_pkg::OFS_EDGE_CFG: d.rdata = {24'h0, q.cfg};
				lsync_pkg::OFS_TIMER:    d.rdata = {16'h0, q.timer};
				lsync_pkg::OFS_CMP:      d.rdata = {16'h0, q.cmp};
				lsync_pkg::OFS_STATUS:   d.rdata = {28'h0, q.sta};
				default:                 d.rdata = 32'h0;
			endcase
		end

		// 5 MHz timer tick, edge counting and sync timer
		d.div = tick ? '0 : q.div + 1'b1; // R11
		if (en) begin // R08
			if (!q.ctrl[lsync_pkg::CTL_MODE]) begin // R02
				if (pin_fall) d.fall_cnt = nf;
				if (pin_rise) d.rise_cnt = nr;
				start_ev = pin_fall && (nf == q.cfg[lsync_pkg::CFG_START_LSB +: 4]); // R12
				if (q.ctrl[lsync_pkg::CTL_EDGE_TYPE]) begin // R01
					stop_ev = q.running && pin_rise &&
						(nr == q.cfg[lsync_pkg::CFG_STOP_LSB +: 4]); // R13
				end else begin
					stop_ev = q.running && pin_fall &&
						(nf == q.cfg[lsync_pkg::CFG_STOP_LSB +: 4]); // R13
				end
			end else begin
				start_ev = pin_fall; // R02
				stop_ev  = q.running && pin_rise; // R02
			end
			if (start_ev) begin
				d.timer   = '0;
				d.running = 1'b1;
			end else if (stop_ev) begin
				d.running = 1'b0; // R14
			end else if (q.running && tick) begin
				d.timer = nt; // R11
				cmp_ev  = q.ctrl[lsync_pkg::CTL_CMP_IE] && (nt == q.cmp); // R03
			end
		end
		// status flags, set wins over clear
		if (start_ev) d.sta[lsync_pkg::STA_START] = 1'b1;
		if (stop_ev)  d.sta[lsync_pkg::STA_STOP]  = 1'b1;
		if (cmp_ev)   d.sta[lsync_pkg::STA_CMP]   = 1'b1; // R04
		// edge counter clear
		if (q.ctrl[lsync_pkg::CTL_EDGE_CLR]) begin
			d.fall_cnt = 4'h0; // R09
			d.rise_cnt = 4'h0; // R09
			d.timer    = '0; // R14
			d.running  = 1'b0;
		end
		// unit reset back to defaults
		if (q.ctrl[lsync_pkg::CTL_UNIT_RST]) begin
			d.ctrl      = (d.ctrl & 8'h03) | (lsync_pkg::CTRL_RESET & 8'hfc); // R10
			d.cfg       = lsync_pkg::CFG_RESET; // R10
			d.cmp       = lsync_pkg::CMP_RESET; // R10
			d.sta       = 4'h0; // R10
			d.fall_cnt  = 4'h0; // R10
			d.rise_cnt  = 4'h0; // R10
			d.timer     = '0; // R10
			d.running   = 1'b0; // R10
		end
		// interrupt gating
		d.irq = (d.sta[lsync_pkg::STA_START] & d.ctrl[lsync_pkg::CTL_START_IE]) | // R07
			(d.sta[lsync_pkg::STA_STOP] & d.ctrl[lsync_pkg::CTL_STOP_IE]) | // R06
			(d.sta[lsync_pkg::STA_CMP] & d.ctrl[lsync_pkg::CTL_CMP_IE]); // R03
		// ready flags
		d.awready = ~d.aw_full & ~d.bvalid;
		d.wready  = ~d.w_full & ~d.bvalid;
		d.arready = ~d.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= RST_S;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign s_axi_awready = q.awready;
	assign s_axi_wready  = q.wready;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rdata   = q.rdata;
	assign s_axi_rresp   = q.rresp;
	assign sync_irq      = q.irq;

endmodule : lsync_core

// ### verif/lsync_core_sva.sv
// checker on the sync control block ports
// assumes control writes offer address and data together
`timescale 1ns/1ps
module lsync_core_sva (
	// clock and reset
	input wire logic	aclk,
	input wire logic	aresetn,
	// write channels
	input wire logic [7:0]	s_axi_awaddr,
	input wire logic	s_axi_awvalid,
	input wire logic	s_axi_awready,
	input wire logic [31:0]	s_axi_wdata,
	input wire logic	s_axi_wvalid,
	input wire logic	s_axi_wready,
	input wire logic [1:0]	s_axi_bresp,
	input wire logic	s_axi_bvalid,
	input wire logic	s_axi_bready,
	// read channels
	input wire logic [7:0]	s_axi_araddr,
	input wire logic	s_axi_arvalid,
	input wire logic	s_axi_arready,
	input wire logic [31:0]	s_axi_rdata,
	input wire logic	s_axi_rvalid,
	input wire logic	s_axi_rready,
	// interrupt
	input wire logic	sync_irq
);
	logic [7:0]	ctl_q;
	logic [1:0]	bits_q;
	logic [8:0]	cnt_q;
	logic		rdc_q;
	wire logic	aw_w;
	assign aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ****************************************
	// shadow of control writes
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_q <= lsync_pkg::CTRL_RESET;
			bits_q <= 2'h0;
			cnt_q <= 9'h1ff;
			rdc_q <= 1'b0;
		end else begin
			if (aw_w && s_axi_awaddr == lsync_pkg::OFS_CTRL) begin
				ctl_q <= s_axi_wdata[7:0];
				if (s_axi_wdata[1:0] != 2'h0) begin
					bits_q <= (cnt_q < 9'h177 ? bits_q : 2'h0) | s_axi_wdata[1:0];
					cnt_q <= 9'h000;
				end
			end else if (cnt_q != 9'h1ff)
				cnt_q <= cnt_q + 9'h001;
			if (s_axi_arvalid && s_axi_arready)
				rdc_q <= s_axi_araddr == lsync_pkg::OFS_CTRL;
		end
	end
	// ****************************************
	// properties
	// ****************************************
	a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_b_answer: assert property (aw_w |=> s_axi_bvalid)
		else $error("write response late");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write channel not released");
	a_irq_gated: assert property (ctl_q[5:3] == 3'h0 && $past(ctl_q[5:3], 2) == 3'h0 && $past(ctl_q[5:3]) == 3'h0 |-> !sync_irq)
		else $error("interrupt with all enables off");
	a_bits_stand: assert property ($rose(s_axi_rvalid) && rdc_q && cnt_q < 9'h172 |-> s_axi_rdata[1:0] == bits_q)
		else $error("self clearing bits dropped early");
	a_self_clear: assert property ($rose(s_axi_rvalid) && rdc_q && cnt_q > 9'h17c |-> s_axi_rdata[1:0] == 2'h0)
		else $error("self clearing bits stuck");
	c_irq: cover property ($rose(sync_irq));
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == lsync_pkg::RESP_SLVERR);
	c_cleared: cover property ($rose(s_axi_rvalid) && rdc_q && cnt_q > 9'h17c);
endmodule : lsync_core_sva
bind lsync_core lsync_core_sva i_lsync_core_sva (.*);

// ### verif/lsync_master.sv
// bus master node model driving the receive pin
// assumes the bus idles recessive high through its pull-up
`timescale 1ns/1ps
module lsync_master (
	// clock
	input wire logic	aclk,
	// bus pin
	output logic	lin_rx
);
	initial lin_rx = 1'b1;
	// low pulse of n cycles, then recessive
	task automatic pulse(input int n);
		lin_rx <= 1'b0;
		repeat (n) @(posedge aclk);
		lin_rx <= 1'b1;
	endtask : pulse
	// break, then sync byte with 100-cycle bits
	task automatic frame();
		pulse(600);
		repeat (100) @(posedge aclk);
		for (int i = 0; i < 4; i++) begin
			pulse(100);
			repeat (100) @(posedge aclk);
		end
	endtask : frame
endmodule : lsync_master

// ### verif/test_lin_sync_control_bits.sv
// self-checking bench for the sync control block
// assumes the master model drives the receive pin
`timescale 1ns/1ps
module test_lin_sync_control_bits;
	logic		aclk = 1'b0;
	logic		aresetn = 1'b0;
	logic [7:0]	s_axi_awaddr = 8'h00;
	logic [7:0]	s_axi_araddr = 8'h00;
	logic [31:0]	s_axi_wdata = 32'h0;
	logic [3:0]	s_axi_wstrb = 4'hf;
	logic		s_axi_awvalid = 1'b0;
	logic		s_axi_wvalid = 1'b0;
	logic		s_axi_bready = 1'b0;
	logic		s_axi_arvalid = 1'b0;
	logic		s_axi_rready = 1'b0;
	logic		s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic		s_axi_rvalid, lin_rx, sync_irq;
	logic [1:0]	s_axi_bresp, s_axi_rresp;
	logic [31:0]	s_axi_rdata;
	int		n_errors = 0;
	int		compares = 0;
	int		cycles = 0;
	lsync_core i_lsync_core (.*);
	lsync_master i_lsync_master (.aclk(aclk), .lin_rx(lin_rx));
	always #20 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_errors++;
			stop_test();
		end
	end
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic stop_test();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				done = 1'b1;
			end
		end
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic done = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				done = 1'b1;
			end
		end
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic wc(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk("bresp", r, lsync_pkg::RESP_OKAY);
	endtask : wc
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk($sformatf("reg %h", a), d, e);
		chk("rresp", r, lsync_pkg::RESP_OKAY);
	endtask : rc
	task automatic tm(input int e);
		logic [31:0] d;
		logic [1:0] r;
		rd(lsync_pkg::OFS_TIMER, d, r);
		chk("timer", d >= e - 1 && d <= e + 1, 1);
	endtask : tm
	task automatic cl(input logic [31:0] v);
		wc(lsync_pkg::OFS_CTRL, v);
		rc(lsync_pkg::OFS_CTRL, v);
		repeat (400) @(posedge aclk);
		rc(lsync_pkg::OFS_CTRL, v & 32'hfc);
	endtask : cl
	task automatic sc(input logic [31:0] v);
		wc(lsync_pkg::OFS_STATUS, v);
		repeat (3) @(posedge aclk);
		chk("irq", sync_irq, 0);
	endtask : sc
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		rc(lsync_pkg::OFS_EDGE_CFG, 32'h32);
		rc(lsync_pkg::OFS_STATUS, 0);
		wc(lsync_pkg::OFS_TIMER, 32'h1234);
		rc(lsync_pkg::OFS_TIMER, 0);
		wc(lsync_pkg::OFS_CMP, 32'h0a);
		rc(lsync_pkg::OFS_CMP, 32'h0a);
		wr(8'h14, 32'h1, r);
		chk("bresp", r, lsync_pkg::RESP_SLVERR);
		rd(8'h14, d, r);
		chk("rresp", r, lsync_pkg::RESP_SLVERR);
	endtask : t_regs
	task automatic t_fall();
		cl(32'h0e);
		i_lsync_master.frame();
		tm(40);
		chk("irq", sync_irq, 1);
		rc(lsync_pkg::OFS_STATUS, 32'h6);
		sc(32'h6);
	endtask : t_fall
	task automatic t_cmp();
		cl(32'h26);
		i_lsync_master.frame();
		rc(lsync_pkg::OFS_STATUS, 32'he);
		chk("irq", sync_irq, 1);
		sc(32'he);
	endtask : t_cmp
	task automatic t_rise();
		cl(32'h96);
		i_lsync_master.frame();
		tm(60);
		chk("irq", sync_irq, 1);
		sc(32'h6);
	endtask : t_rise
	task automatic t_mode();
		cl(32'h46);
		i_lsync_master.pulse(150);
		repeat (20) @(posedge aclk);
		tm(30);
		chk("irq", sync_irq, 0);
		rc(lsync_pkg::OFS_STATUS, 32'h6);
		wc(lsync_pkg::OFS_CTRL, 32'h64);
		i_lsync_master.pulse(150);
		repeat (20) @(posedge aclk);
		chk("irq", sync_irq, 1);
		rc(lsync_pkg::OFS_STATUS, 32'he);
	endtask : t_mode
	task automatic t_cfg();
		wc(lsync_pkg::OFS_EDGE_CFG, 32'h53);
		rc(lsync_pkg::OFS_EDGE_CFG, 32'h53);
		cl(32'h06);
		i_lsync_master.frame();
		tm(80);
	endtask : t_cfg
	task automatic t_unit();
		cl(32'h01);
		rc(lsync_pkg::OFS_STATUS, 0);
		rc(lsync_pkg::OFS_CMP, 0);
		rc(lsync_pkg::OFS_EDGE_CFG, 32'h32);
		rc(lsync_pkg::OFS_TIMER, 0);
		i_lsync_master.frame();
		rc(lsync_pkg::OFS_TIMER, 0);
		rc(lsync_pkg::OFS_STATUS, 0);
	endtask : t_unit
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rc(lsync_pkg::OFS_CTRL, 0);
		t_regs();
		t_fall();
		t_cmp();
		t_rise();
		t_mode();
		t_cfg();
		t_unit();
		stop_test();
	end
endmodule : test_lin_sync_control_bits
